// >>> frtps_pkg.sv
// Shared constants and types for the fault retry and power-fail stop block
package frtps_pkg;
  localparam int          CLK_HZ      = 125_000_000;
  localparam int          TICK_MS     = 100;
  localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int          SUCC_MULT   = 4;
  localparam logic [13:0] COAST_OFF   = 14'h270f;
  localparam logic [12:0] WAIT_RST    = 13'h000a;
  localparam logic [12:0] WAIT_MIN    = 13'h0001;
  localparam logic [12:0] WAIT_MAX    = 13'h1770;
  localparam logic [6:0]  CNT_MUL_LO  = 7'h65;
  localparam logic [6:0]  CNT_MUL_HI  = 7'h6e;
  localparam logic [6:0]  CNT_PLAIN   = 7'h0a;
  localparam logic [6:0]  CNT_OFS     = 7'h64;
  localparam logic [7:0]  FN_PFD      = 8'h2e;
  localparam logic [7:0]  FN_PFD_N    = 8'h92;
  localparam logic [7:0]  FN_RTA      = 8'h40;
  localparam logic [7:0]  FN_RTA_N    = 8'ha4;
  localparam logic [1:0]  PF_COAST    = 2'h0;
  localparam logic [1:0]  PF_STOP     = 2'h1;
  localparam logic [1:0]  PF_CONT     = 2'h2;
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_COUNT     = 8'h04;
  localparam logic [7:0]  A_WAIT      = 8'h08;
  localparam logic [7:0]  A_COAST     = 8'h0c;
  localparam logic [7:0]  A_SUCC      = 8'h10;
  localparam logic [7:0]  A_STAT      = 8'h14;
  localparam logic [7:0]  A_TERM      = 8'h18;
  localparam int          CTRL_CLR    = 8;
  // Retry masks, bit 15 is the accel overcurrent trip
  localparam logic [15:0] MASK_ALL    = 16'hffff;
  localparam logic [15:0] MASK_OC     = 16'he000;
  localparam logic [15:0] MASK_OV     = 16'h1c00;
  localparam logic [15:0] MASK_OCOV   = 16'hfc00;
  localparam logic [15:0] MASK_EXT    = 16'hfccf;
  localparam logic [15:0] MASK_ACDC   = 16'ha000;
  localparam logic [15:0] MASK_PE     = 16'h0004;

  typedef struct packed {
    logic overcurrent_accel_trip;
    logic overcurrent_const_trip;
    logic overcurrent_decel_trip;
    logic overvoltage_accel_trip;
    logic overvoltage_const_trip;
    logic overvoltage_decel_trip;
    logic motor_overload_trip;
    logic drive_overload_trip;
    logic brake_transistor_trip;
    logic ground_fault_trip;
    logic ext_thermal_trip;
    logic thermistor_trip;
    logic stall_prevention_trip;
    logic param_storage_trip;
    logic input_phase_loss_trip;
    logic output_current_detect_trip;
  } frtps_faults_t;

  typedef struct packed {
    logic out_shutoff;
    logic dc_bus_decel;
    logic normal_decel;
    logic reaccel;
  } frtps_pf_cmd_t;

  typedef enum logic [2:0] {PF_IDLE, PF_COASTING, PF_DECEL, PF_STOPPED} frtps_pf_st_t;
  typedef enum logic [1:0] {RT_IDLE, RT_WAIT, RT_RUN, RT_EXCESS} frtps_rt_st_t;
endpackage

// >>> frtps_core.sv
// Power-fail stop sequencing and automatic fault retry with AHB-Lite registers
`timescale 1ns/1ns
// Summary of operation
// - Power loss decel regulates bus to 0Hz
// - Selection 0 shuts output, motor coasts
// - Selection 1 finishes stop, needs restart
// - Held start ignored; only fresh edge restarts
// - Coast time not 9999 disables stop
// - Selection 2 reaccelerates when power returns
// - Selection 2, start dropped during outage: normal decel
// - Decel flag during decel and after stop
// - Decel flag on terminal code 46/146
// - No power-fail handling when stopped/tripped
// - Retry only faults in selected set
// - Selection 0 to 5 maps fault sets
// - Count 0 off; 1-10 no fault output
// - Count 101-110: minus 100, fault shown
// - Wait time, clear fault, restart
// - Failures reaching count raise excess trip
// - Success after four wait times runs
// - Success counter readable, write 0 clears
// - Retry flag on terminal code 64/164
// - Retry restart uses power-loss restart path when coast time not 9999
// - Power-on storage fault never retried
module frtps_core
  import frtps_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic          mclk,              // 125 MHz clock
  input  wire logic          rst,               // Sync reset, high
  input  wire logic          hsel,              // AHB select
  input  wire logic [31:0]   haddr,             // AHB address
  input  wire logic [1:0]    htrans,            // AHB transfer type
  input  wire logic          hwrite,            // AHB write
  input  wire logic [2:0]    hsize,             // AHB size
  input  wire logic [31:0]   hwdata,            // AHB write data
  input  wire logic          hready,            // AHB bus ready
  output logic               hreadyout,         // AHB slave ready
  output logic               hresp,             // AHB response
  output logic [31:0]        hrdata,            // AHB read data
  input  wire logic          forward_start_in,  // Forward start
  input  wire logic          reverse_start_in,  // Reverse start
  input  wire logic          undervolt_in,      // Undervoltage or power loss
  input  wire logic          drive_running_in,  // Output active
  input  wire logic          at_zero_freq_in,   // Output reached 0Hz
  input  wire frtps_faults_t fault_in,          // Trip pulses
  input  wire logic          pe_at_powerup_in,  // Storage fault seen at power on
  output frtps_pf_cmd_t      pf_cmd,            // Power-fail drive commands
  output logic               run_permit,        // Start allowed
  output logic               ips_mode,          // Auto restart selected
  output logic               retry_restart,     // Clear fault, restart pulse
  output logic               retry_ips_restart, // Restart via power-loss path
  output logic               fault_out,         // Fault output
  output logic               retry_excess_trip, // Retry count excess
  output logic               pwr_fail_decel_flag, // Power-fail decel status
  output logic               retry_active_flag, // Retry in progress
  output logic [2:0]         term_out           // Assignable terminals
);

  // Register state
  logic [1:0]    pf_sel_reg;
  logic [2:0]    fsel_reg;
  logic [6:0]    cnt_set_reg;
  logic [12:0]   wait_reg;
  logic [13:0]   coast_reg;
  logic [15:0]   succ_reg;
  logic [23:0]   term_reg;
  // Bus pipeline
  logic          wr_pend_reg;
  logic [7:0]    wr_addr_reg;
  // Sequencer state
  frtps_pf_st_t  pf_st_reg;
  frtps_pf_st_t  pf_st_next;
  frtps_rt_st_t  rt_st_reg;
  frtps_rt_st_t  rt_st_next;
  logic          start_d_reg;
  logic          start_low_reg;
  logic          trip_reg;
  logic [3:0]    fail_reg;
  logic [3:0]    fail_next;
  logic [14:0]   tmr_reg;
  logic [23:0]   div_reg;
  logic          restart_reg;
  logic          excess_reg;
  logic          reaccel_reg;

  // Bus decode
  wire           bus_req  = hsel && hready && htrans[1];
  wire           bus_wr   = bus_req && hwrite;
  wire           bus_rd   = bus_req && !hwrite;
  wire [7:0]     rd_addr  = haddr[7:0];
  wire           wr_ctrl  = wr_pend_reg && wr_addr_reg == A_CTRL;
  wire           wr_count = wr_pend_reg && wr_addr_reg == A_COUNT;
  wire           wr_wait  = wr_pend_reg && wr_addr_reg == A_WAIT;
  wire           wr_coast = wr_pend_reg && wr_addr_reg == A_COAST;
  wire           wr_succ  = wr_pend_reg && wr_addr_reg == A_SUCC;
  wire           wr_term  = wr_pend_reg && wr_addr_reg == A_TERM;
  wire           sw_clear = wr_ctrl && hwdata[CTRL_CLR];
  wire           succ_clr = wr_succ && hwdata[15:0] == 16'h0000;
  wire           wait_ok  = hwdata[12:0] >= WAIT_MIN && hwdata[12:0] <= WAIT_MAX;

  // Start and timing
  wire           start     = forward_start_in || reverse_start_in;
  wire           start_rise = start && !start_d_reg;
  wire           tick      = div_reg == 24'(TICK_CYCLES - 1);
  wire           pf_enable = coast_reg == COAST_OFF;
  wire           any_fault = |fault_in;

  // Retry eligibility
  logic [15:0]   sel_mask;
  always_comb begin
    case (fsel_reg)
      3'h0:    sel_mask = MASK_ALL;
      3'h1:    sel_mask = MASK_OC;
      3'h2:    sel_mask = MASK_OV;
      3'h3:    sel_mask = MASK_OCOV;
      3'h4:    sel_mask = MASK_EXT;
      3'h5:    sel_mask = MASK_ACDC;
      default: sel_mask = 16'h0000;
    endcase
  end
  wire [15:0]    pe_block  = pe_at_powerup_in ? MASK_PE : 16'h0000;
  wire           eligible  = |(fault_in & sel_mask & ~pe_block);
  wire           cnt_plain = cnt_set_reg >= 7'h01 && cnt_set_reg <= CNT_PLAIN;
  wire           cnt_mul   = cnt_set_reg >= CNT_MUL_LO && cnt_set_reg <= CNT_MUL_HI;
  wire           retry_on  = cnt_plain || cnt_mul;
  wire [6:0]     lim_full  = cnt_mul ? cnt_set_reg - CNT_OFS : cnt_set_reg;
  wire [3:0]     limit     = lim_full[3:0];
  wire [14:0]    wait_t    = {2'h0, wait_reg};
  wire [14:0]    succ_t    = 15'(wait_reg * SUCC_MULT);
  wire           wait_done = tmr_reg >= wait_t;
  wire           succ_done = tmr_reg > succ_t;

  // Power-fail sequencer
  always_comb begin
    pf_st_next = pf_st_reg;
    case (pf_st_reg)
      PF_IDLE: begin
        if (undervolt_in && pf_enable && drive_running_in && !trip_reg) begin
          if (pf_sel_reg == PF_COAST) begin
            pf_st_next = PF_COASTING;
          end else if (pf_sel_reg == PF_STOP || pf_sel_reg == PF_CONT) begin
            pf_st_next = PF_DECEL;
          end
        end
      end
      PF_COASTING: begin
        if (!undervolt_in) begin
          pf_st_next = PF_IDLE;
        end
      end
      PF_DECEL: begin
        if (pf_sel_reg == PF_CONT && !undervolt_in && start) begin
          pf_st_next = PF_IDLE;
        end else if (at_zero_freq_in) begin
          pf_st_next = PF_STOPPED;
        end
      end
      PF_STOPPED: begin
        if (!undervolt_in && start_low_reg && start_rise) begin
          pf_st_next = PF_IDLE;
        end
      end
      default: pf_st_next = PF_IDLE;
    endcase
  end

  // Retry sequencer
  always_comb begin
    rt_st_next = rt_st_reg;
    fail_next  = fail_reg;
    case (rt_st_reg)
      RT_IDLE: begin
        if (any_fault && eligible && retry_on) begin
          rt_st_next = RT_WAIT;
        end
      end
      RT_WAIT: begin
        if (wait_done) begin
          rt_st_next = RT_RUN;
        end
      end
      RT_RUN: begin
        if (any_fault && eligible) begin
          fail_next = fail_reg + 4'h1;
          rt_st_next = (fail_next >= limit) ? RT_EXCESS : RT_WAIT;
        end else if (any_fault) begin
          rt_st_next = RT_IDLE;
        end else if (succ_done) begin
          fail_next  = 4'h0;
          rt_st_next = RT_IDLE;
        end
      end
      RT_EXCESS: begin
        if (sw_clear) begin
          rt_st_next = RT_IDLE;
          fail_next  = 4'h0;
        end
      end
      default: rt_st_next = RT_IDLE;
    endcase
    if (!retry_on) begin
      rt_st_next = RT_IDLE;
    end
  end

  wire rt_enter   = rt_st_reg != rt_st_next;
  wire do_restart = rt_st_reg == RT_WAIT && wait_done && retry_on;
  wire do_succ    = rt_st_reg == RT_RUN && !any_fault && succ_done && retry_on;

  // Terminal function select
  function automatic logic term_map(input logic [7:0] code, input logic pfd,
                                    input logic rta);
    logic v;
    v = 1'b0;
    if (code == FN_PFD) v = pfd;
    if (code == FN_PFD_N) v = !pfd;
    if (code == FN_RTA) v = rta;
    if (code == FN_RTA_N) v = !rta;
    return v;
  endfunction

  // Bus slave, zero wait states
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_wr;
      wr_addr_reg <= rd_addr;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (rd_addr)
      A_CTRL:  rd_mux = {25'h0, fsel_reg, 2'h0, pf_sel_reg};
      A_COUNT: rd_mux = {25'h0, cnt_set_reg};
      A_WAIT:  rd_mux = {19'h0, wait_reg};
      A_COAST: rd_mux = {18'h0, coast_reg};
      A_SUCC:  rd_mux = {16'h0, succ_reg};
      A_STAT:  rd_mux = {21'h0, fail_reg, 1'b0, rt_st_reg, pf_st_reg,
                         trip_reg};
      A_TERM:  rd_mux = {8'h0, term_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      hrdata <= rd_mux;
    end
  end

  // Software settings
  always_ff @(posedge mclk) begin
    if (rst) begin
      pf_sel_reg  <= PF_COAST;
      fsel_reg    <= 3'h0;
      cnt_set_reg <= 7'h00;
      wait_reg    <= WAIT_RST;
      coast_reg   <= COAST_OFF;
      term_reg    <= 24'h000000;
    end else begin
      if (wr_ctrl) begin
        pf_sel_reg <= hwdata[1:0];
        fsel_reg   <= hwdata[6:4];
      end
      if (wr_count) cnt_set_reg <= hwdata[6:0];
      if (wr_wait && wait_ok) wait_reg <= hwdata[12:0];
      if (wr_coast) coast_reg <= hwdata[13:0];
      if (wr_term) term_reg <= hwdata[23:0];
    end
  end

  // Success counter, clear together with increment loads 1
  always_ff @(posedge mclk) begin
    if (rst) begin
      succ_reg <= 16'h0000;
    end else if (do_succ) begin
      succ_reg <= succ_clr ? 16'h0001 : succ_reg + 16'h0001;
    end else if (succ_clr) begin
      succ_reg <= 16'h0000;
    end
  end

  // Tick divider for 0.1 s units
  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      div_reg <= 24'h000000;
    end else begin
      div_reg <= div_reg + 24'h000001;
    end
  end

  // Retry timer restarts on each state change
  always_ff @(posedge mclk) begin
    if (rst || rt_enter || rt_st_reg == RT_IDLE) begin
      tmr_reg <= 15'h0000;
    end else if (tick && tmr_reg != 15'h7fff) begin
      tmr_reg <= tmr_reg + 15'h0001;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      pf_st_reg     <= PF_IDLE;
      rt_st_reg     <= RT_IDLE;
      fail_reg      <= 4'h0;
      start_d_reg   <= 1'b0;
      start_low_reg <= 1'b0;
      restart_reg   <= 1'b0;
      excess_reg    <= 1'b0;
      reaccel_reg   <= 1'b0;
    end else begin
      pf_st_reg   <= pf_st_next;
      rt_st_reg   <= rt_st_next;
      fail_reg    <= retry_on ? fail_next : 4'h0;
      start_d_reg <= start;
      restart_reg <= do_restart;
      excess_reg  <= rt_st_next == RT_EXCESS;
      reaccel_reg <= pf_st_reg == PF_DECEL && pf_st_next == PF_IDLE;
      // Edge counts only after start was seen low in the stopped state
      if (pf_st_reg != PF_STOPPED) begin
        start_low_reg <= 1'b0;
      end else if (!start) begin
        start_low_reg <= 1'b1;
      end
    end
  end

  // Trip latch, a new fault wins over any clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_reg <= 1'b0;
    end else if (any_fault) begin
      trip_reg <= 1'b1;
    end else if (do_restart || (sw_clear && rt_st_reg != RT_WAIT)) begin
      trip_reg <= 1'b0;
    end
  end

  // Outputs
  wire in_decel   = pf_st_reg == PF_DECEL;
  wire pfd        = in_decel || pf_st_reg == PF_STOPPED;
  wire rta        = rt_st_reg == RT_WAIT;
  wire hide_fault = rta && cnt_plain;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pf_cmd              <= '0;
      pwr_fail_decel_flag <= 1'b0;
      retry_active_flag   <= 1'b0;
      fault_out           <= 1'b0;
      term_out            <= 3'h0;
    end else begin
      pf_cmd.out_shutoff  <= pf_st_reg == PF_COASTING;
      pf_cmd.dc_bus_decel <= in_decel && (start || pf_sel_reg != PF_CONT);
      pf_cmd.normal_decel <= in_decel && !start && pf_sel_reg == PF_CONT;
      pf_cmd.reaccel      <= reaccel_reg;
      pwr_fail_decel_flag <= pfd;
      retry_active_flag   <= rta;
      fault_out           <= (trip_reg && !hide_fault) || rt_st_next == RT_EXCESS;
      term_out[0]         <= term_map(term_reg[7:0], pfd, rta);
      term_out[1]         <= term_map(term_reg[15:8], pfd, rta);
      term_out[2]         <= term_map(term_reg[23:16], pfd, rta);
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign retry_restart     = restart_reg;
  assign retry_ips_restart = restart_reg && !pf_enable;
  assign ips_mode          = !pf_enable;
  assign retry_excess_trip = excess_reg;
  assign run_permit        = start && !trip_reg && pf_st_reg == PF_IDLE;

endmodule

// >>> frtps_core_assertions.sv
// Concurrent checks on the fault retry and power-fail stop ports
`timescale 1ns/1ns
module frtps_core_assertions
  import frtps_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic          mclk,                // Clock
  input wire logic          rst,                 // Reset
  input wire logic          hreadyout,           // Bus ready
  input wire logic          hresp,               // Bus resp
  input wire logic          forward_start_in,    // Fwd start
  input wire logic          reverse_start_in,    // Rev start
  input wire logic          undervolt_in,        // Power loss
  input wire logic          drive_running_in,    // Running
  input wire frtps_pf_cmd_t pf_cmd,              // Commands
  input wire logic          run_permit,          // Permit
  input wire logic          ips_mode,            // Restart mode
  input wire logic          retry_restart,       // Restart
  input wire logic          retry_ips_restart,   // Restart path
  input wire logic          fault_out,           // Fault out
  input wire logic          retry_excess_trip,   // Excess
  input wire logic          pwr_fail_decel_flag, // Decel flag
  input wire logic          retry_active_flag    // Retry flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled");
  a_permit_start: assert property (run_permit |-> forward_start_in || reverse_start_in)
    else $error("permit without start");
  a_ips_path: assert property (retry_ips_restart |-> retry_restart && ips_mode)
    else $error("bad restart path");
  a_restart_pulse: assert property (retry_restart |=> !retry_restart)
    else $error("restart not a pulse");
  a_restart_ends: assert property (retry_restart |-> ##2 !retry_active_flag)
    else $error("retry flag stuck");
  a_decel_flag: assert property (pf_cmd.dc_bus_decel |-> pwr_fail_decel_flag)
    else $error("decel without flag");
  // Entry needs a running drive two edges earlier; stopped drive is left alone
  a_decel_cause: assert property ($rose(pf_cmd.dc_bus_decel) |->
    $past(undervolt_in, 2) && $past(drive_running_in, 2))
    else $error("decel without cause");
  a_coast_only: assert property (pf_cmd.out_shutoff |-> !pf_cmd.dc_bus_decel)
    else $error("coast and decel");
  a_excess_fault: assert property (retry_excess_trip |-> fault_out)
    else $error("excess without fault");
  a_reaccel_pulse: assert property (pf_cmd.reaccel |=> !pf_cmd.reaccel)
    else $error("reaccel not a pulse");

  c_decel: cover property ($rose(pwr_fail_decel_flag));
  c_restart: cover property (retry_restart);
  c_excess: cover property ($rose(retry_excess_trip));
endmodule

bind frtps_core frtps_core_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk, .rst, .hreadyout, .hresp, .forward_start_in, .reverse_start_in,
  .undervolt_in, .drive_running_in, .pf_cmd, .run_permit, .ips_mode,
  .retry_restart, .retry_ips_restart, .fault_out, .retry_excess_trip,
  .pwr_fail_decel_flag, .retry_active_flag
);

// >>> frtps_op_model.sv
// Operator side model: start switches and terminal lamps
`timescale 1ns/1ns
module frtps_op_model (
  input  wire logic       mclk,                    // Clock
  input  wire logic       start_req,               // Run wanted
  input  wire logic       rev_req,                 // Reverse wanted
  input  wire logic [2:0] term_out,                // Terminals
  output logic            forward_start_in = 1'b0, // Fwd switch
  output logic            reverse_start_in = 1'b0, // Rev switch
  output logic [2:0]      term_seen = 3'h0         // Lamps
);
  // Switches move only after an edge and stay put through an outage
  always @(posedge mclk) begin
    forward_start_in <= start_req && !rev_req;
    reverse_start_in <= start_req && rev_req;
    term_seen        <= term_out;
  end
endmodule

// >>> tb_top.sv
// Bench for the fault retry and power-fail stop block
`timescale 1ns/1ns
module tb_top import frtps_pkg::*;;
  localparam int          TC = 4;
  localparam logic [15:0] MSK [6] = '{16'hffff, 16'he000, 16'h1c00, 16'hfc00, 16'hfccf,
                                      16'ha000};
  logic          mclk, hready, hreadyout, hresp, run_permit, ips_mode, fault_out;
  logic          rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, start_req = 1'b1, rev_req = 1'b0;
  logic          undervolt_in = 1'b0, drive_running_in = 1'b1, at_zero_freq_in = 1'b0;
  logic          pe_at_powerup_in = 1'b0, forward_start_in, reverse_start_in;
  logic          retry_restart, retry_ips_restart, retry_excess_trip;
  logic          pwr_fail_decel_flag, retry_active_flag;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize = 3'h2, term_out, term_seen;
  logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  frtps_faults_t fault_in = '0;
  frtps_pf_cmd_t pf_cmd;
  int            failures = 0, checks = 0;

  assign hready = hreadyout;

  frtps_core #(.TICK_CYCLES(TC)) i_frtps_core (
    .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .forward_start_in, .reverse_start_in,
    .undervolt_in, .drive_running_in, .at_zero_freq_in, .fault_in,
    .pe_at_powerup_in, .pf_cmd, .run_permit, .ips_mode, .retry_restart,
    .retry_ips_restart, .fault_out, .retry_excess_trip, .pwr_fail_decel_flag,
    .retry_active_flag, .term_out
  );
  frtps_op_model i_frtps_op_model (
    .mclk, .start_req, .rev_req, .term_out, .forward_start_in, .reverse_start_in,
    .term_seen
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Holds each phase until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask

  // One-cycle trip pulse on struct bit b
  task automatic hit(input int b);
    fault_in <= frtps_faults_t'(16'h1 << b);
    @(posedge mclk);
    fault_in <= '0;
  endtask

  task automatic wait_rs(input logic ips);
    int i;
    i = 0;
    while (retry_restart !== 1'b1 && i < 40) begin
      @(posedge mclk);
      i++;
    end
    chk(retry_restart, 1'b1, "restart");
    chk(retry_ips_restart, ips, "ips restart");
  endtask

  task automatic t_reset;
    rdc(A_CTRL, 32'h0, "ctrl");
    rdc(A_COUNT, 32'h0, "count");
    rdc(A_WAIT, 32'd10, "wait");
    rdc(A_COAST, 32'd9999, "coast");
    rdc(A_SUCC, 32'h0, "succ");
    rdc(8'h1c, 32'h0, "unmapped");
    chk(ips_mode, 1'b0, "ips");
    wr(A_TERM, 32'h00a4922e);
    cyc(4);
    chk(term_seen, 3'b110, "term idle");
    $display("done reset");
  endtask

  task automatic t_pf_stop;
    wr(A_CTRL, 32'h1);
    undervolt_in <= 1'b1;
    cyc(5);
    chk(pf_cmd.dc_bus_decel, 1'b1, "decel");
    chk(term_seen[0], 1'b1, "term flag");
    undervolt_in <= 1'b0;
    cyc(5);
    chk(pf_cmd.dc_bus_decel, 1'b1, "keep decel");
    at_zero_freq_in <= 1'b1;
    drive_running_in <= 1'b0;
    cyc(5);
    chk(pwr_fail_decel_flag, 1'b1, "stop flag");
    chk(run_permit, 1'b0, "held start");
    start_req <= 1'b0;
    cyc(3);
    start_req <= 1'b1;
    rev_req <= 1'b1;
    cyc(6);
    chk(pwr_fail_decel_flag, 1'b0, "flag off");
    chk(run_permit, 1'b1, "fresh start");
    at_zero_freq_in <= 1'b0;
    drive_running_in <= 1'b1;
    $display("done pf stop");
  endtask

  task automatic t_pf_coast;
    wr(A_CTRL, 32'h0);
    undervolt_in <= 1'b1;
    cyc(5);
    chk(pf_cmd.out_shutoff, 1'b1, "coast");
    chk(pwr_fail_decel_flag, 1'b0, "no flag");
    undervolt_in <= 1'b0;
    cyc(5);
    chk(pf_cmd.out_shutoff, 1'b0, "coast end");
    wr(A_CTRL, 32'h1);
    wr(A_COAST, 32'd5);
    undervolt_in <= 1'b1;
    cyc(5);
    chk(ips_mode, 1'b1, "ips on");
    chk(pf_cmd, 4'h0, "no stop in ips");
    undervolt_in <= 1'b0;
    wr(A_COAST, 32'd9999);
    drive_running_in <= 1'b0;
    undervolt_in <= 1'b1;
    cyc(5);
    chk(pf_cmd, 4'h0, "stopped ignored");
    undervolt_in <= 1'b0;
    drive_running_in <= 1'b1;
    $display("done pf coast");
  endtask

  task automatic t_retry_sets;
    wr(A_COUNT, 32'd1);
    wr(A_WAIT, 32'd2);
    for (int s = 0; s < 6; s++) begin
      wr(A_CTRL, 32'(s) << 4);
      for (int b = 0; b < 16; b++) begin
        hit(b);
        cyc(2);
        chk(retry_active_flag, MSK[s][b], "retry set");
        chk(fault_out, !MSK[s][b], "fault out");
        cyc(60);
        wr(A_CTRL, (32'(s) << 4) | 32'h100);
      end
    end
    wr(A_CTRL, 32'h0);
    pe_at_powerup_in <= 1'b1;
    hit(2);
    cyc(2);
    chk(retry_active_flag, 1'b0, "storage fault");
    pe_at_powerup_in <= 1'b0;
    wr(A_CTRL, 32'h100);
    rdc(A_SUCC, 32'd42, "succ count");
    wr(A_SUCC, 32'd5);
    rdc(A_SUCC, 32'd42, "succ kept");
    wr(A_SUCC, 32'h0);
    rdc(A_SUCC, 32'h0, "succ clear");
    $display("done retry sets");
  endtask

  task automatic t_excess;
    wr(A_COUNT, 32'd102);
    wr(A_COAST, 32'd5);
    hit(15);
    cyc(2);
    chk(fault_out, 1'b1, "fault shown");
    wait_rs(1'b1);
    cyc(3);
    hit(15);
    wait_rs(1'b1);
    cyc(3);
    hit(15);
    cyc(3);
    chk(retry_excess_trip, 1'b1, "excess");
    wr(A_CTRL, 32'h100);
    wr(A_COUNT, 32'h0);
    wr(A_COAST, 32'd9999);
    hit(15);
    cyc(2);
    chk(retry_active_flag, 1'b0, "retry off");
    wr(A_CTRL, 32'h100);
    $display("done excess");
  endtask

  task automatic t_pf_cont;
    logic seen;
    wr(A_CTRL, 32'h2);
    undervolt_in <= 1'b1;
    cyc(5);
    chk(pf_cmd.dc_bus_decel, 1'b1, "cont decel");
    undervolt_in <= 1'b0;
    seen = 1'b0;
    repeat (6) begin
      @(posedge mclk);
      seen |= (pf_cmd.reaccel === 1'b1);
    end
    chk(seen, 1'b1, "reaccel");
    start_req <= 1'b0;
    cyc(3);
    undervolt_in <= 1'b1;
    cyc(5);
    chk(pf_cmd.normal_decel, 1'b1, "normal decel");
    chk(pf_cmd.dc_bus_decel, 1'b0, "no bus decel");
    $display("done pf cont");
  endtask

  initial begin
    cyc(20);
    rst <= 1'b0;
    t_reset;
    t_pf_stop;
    t_pf_coast;
    t_retry_sets;
    t_excess;
    t_pf_cont;
    test_done;
  end

  // Whole run is well under 10,000 cycles
  initial begin
    #300000;
    failures++;
    $display("mismatch %0t watchdog", $time);
    test_done;
  end
endmodule
